/* File: reset_source_control_map.svh */
// Constants for the reset source controller: field positions, resets, timing
`ifndef RESET_SOURCE_CONTROL_MAP_SVH
`define RESET_SOURCE_CONTROL_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define RSC_ADDR_CAUSE   4'h0
`define RSC_ADDR_CTRL    4'h1
`define RSC_ADDR_IRQ_ST  4'h2
`define RSC_ADDR_IRQ_MSK 4'h3
`define RSC_ADDR_WDT     4'h4
`define RSC_ADDR_WDT_HI  4'h5
`define RSC_ADDR_WIN     4'h6

// ****************************************
// Cause register fields
// ****************************************
`define RSC_CAUSE_TO    0
`define RSC_CAUSE_PD    1
`define RSC_CAUSE_WATCHDOG_RESET_FLAG_N  2
`define RSC_CAUSE_WV    3
`define RSC_CAUSE_RI    4
`define RSC_CAUSE_OVF   5
`define RSC_CAUSE_UNF   6
`define RSC_CAUSE_POR   7
`define RSC_CAUSE_RESET 8'h1F

// ****************************************
// Control register fields
// ****************************************
`define RSC_CTRL_PULLUP 0
`define RSC_CTRL_WDTEN  1
`define RSC_CTRL_RESET  8'h02

// ****************************************
// Interrupt status fields
// ****************************************
`define RSC_IRQ_PIN   0
`define RSC_IRQ_WDT   1
`define RSC_IRQ_RI    2
`define RSC_IRQ_STACK 3
`define RSC_IRQ_BOR   4

// ****************************************
// Timing
// ****************************************
`define RSC_FILTER_NS    200
`define RSC_CLK_NS       10
`define RSC_FILTER_CYC   (`RSC_FILTER_NS / `RSC_CLK_NS)
`define RSC_WDT_TIMEOUT  16'hFFFF
`define RSC_WDT_WINDOW   16'h0000
`define RSC_HOLD_CYC     16

`endif

/* File: reset_source_pkg.sv */
// Types shared by the reset source controller
package reset_source_pkg;
   typedef enum logic [1:0] {
      RST_IDLE,
      RST_HOLD,
      RST_RELEASE
   } rst_state_t;
   typedef logic [7:0] reg_byte_t;
endpackage : reset_source_pkg

/* File: reset_pin_filter.sv */
// Glitch filter on the external reset pin
`timescale 1ns/1ps
`default_nettype none
module reset_pin_filter #(
   parameter int CYCLES = 20
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic pin_in,
   output logic      filtered_low
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_filtered_low;

   // Low level must persist CYCLES+1 cycles; shorter pulses are dropped
   always_comb begin
      next_count = count;
      next_filtered_low = filtered_low;
      if (pin_in) begin
         next_count = '0;
         next_filtered_low = 1'b0;
      end else if (count == CW'(CYCLES)) begin
         next_filtered_low = 1'b1;
      end else begin
         next_count = count + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count <= '0;
         filtered_low <= 1'b0;
      end else begin
         count <= next_count;
         filtered_low <= next_filtered_low;
      end
   end
endmodule : reset_pin_filter
`default_nettype wire

/* File: reset_source_control.sv */
// Reset source controller: pin, watchdog, instruction and stack resets
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01: The pin reset works when low-voltage programming is on, else per its enable.
// R02: With the pin function on, a low pin holds the device in reset.
// R03: Short low pulses on the pin are filtered out.
// R04: Internal resets never drive the pin low.
// R05: With the pin function off the pin is an input with software pull-up.
// R06: Watchdog resets on timeout or on a clear outside the window.
// R07: A watchdog reset updates timeout, power-down and watchdog cause flags.
// R08: A flag records timeout versus window violation.
// R09: The reset instruction resets the device and clears its cause flag.
// R10: Stack faults reset only when the stack-fault reset is enabled.
// R11: A stack-fault reset sets the matching overflow or underflow flag.
// R12: All sources merge into one reset; flags hold until rewritten or power-on.
`include "reset_source_control_map.svh"
module reset_source_control #(
   parameter int FILTER_CYCLES = `RSC_FILTER_CYC,
   parameter int HOLD_CYCLES   = `RSC_HOLD_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   power_on_reset,
   input  wire logic                   brownout_reset,
   input  wire logic                   ext_reset_pin_enable,
   input  wire logic                   low_voltage_program_enable,
   input  wire logic                   stack_fault_reset_enable,
   input  wire logic                   master_clear_pin_in,
   input  wire logic                   watchdog_clear_instruction,
   input  wire logic                   reset_instruction,
   input  wire logic                   sleep_instruction,
   input  wire logic                   stack_overflow,
   input  wire logic                   stack_underflow,
   input  wire logic [3:0]             addr,
   input  wire logic [7:0]             wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output reset_source_pkg::reg_byte_t rdata,
   output logic                        master_clear_pin_out,
   output logic                        master_clear_pin_oe,
   output logic                        pin_pullup_en,
   output logic                        pin_is_reset,
   output logic                        device_reset,
   output logic                        irq
);
   import reset_source_pkg::*;

   // ****************************************
   // State
   // ****************************************
   rst_state_t state, next_state;
   logic [4:0]  hold_cnt, next_hold_cnt;
   reg_byte_t   cause, next_cause;
   reg_byte_t   ctrl, next_ctrl;
   logic [4:0]  irq_st, next_irq_st;
   logic [4:0]  irq_msk, next_irq_msk;
   logic [15:0] wdt_cnt, next_wdt_cnt;
   logic [15:0] wdt_timeout, next_wdt_timeout;
   logic [15:0] wdt_window, next_wdt_window;
   reg_byte_t   next_rdata;
   logic        next_pin_pullup_en;
   logic        next_pin_is_reset;
   logic        next_device_reset;
   logic        next_irq;
   logic        pin_low;
   logic        pin_fn;
   logic        wdt_expire;
   logic        wdt_early;
   logic        stack_rst;
   logic        any_rst;

   function automatic logic [15:0] merge_lo(input logic [15:0] v,
                                            input logic [7:0] b);
      merge_lo = {v[15:8], b};
   endfunction : merge_lo

   function automatic logic [15:0] merge_hi(input logic [15:0] v,
                                            input logic [7:0] b);
      merge_hi = {b, v[7:0]};
   endfunction : merge_hi

   // ****************************************
   // Source detection
   // ****************************************
   assign pin_fn = low_voltage_program_enable
                 | ext_reset_pin_enable;                        // [R01]

   reset_pin_filter #(
      .CYCLES       (FILTER_CYCLES)
   ) u_filter (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .pin_in       (master_clear_pin_in),
      .filtered_low (pin_low)                                  // [R03]
   );

   assign wdt_expire = ctrl[`RSC_CTRL_WDTEN] && state == RST_IDLE
                     && wdt_cnt >= wdt_timeout;                 // [R06]
   assign wdt_early = ctrl[`RSC_CTRL_WDTEN] && state == RST_IDLE
                    && watchdog_clear_instruction
                    && wdt_cnt < wdt_window;                    // [R06]
   assign stack_rst = stack_fault_reset_enable
                    && (stack_overflow || stack_underflow);     // [R10]
   // Pin reset is a level: the hold lasts as long as the pin stays low
   assign any_rst = (pin_fn && pin_low) || brownout_reset
                  || wdt_expire || wdt_early || reset_instruction
                  || stack_rst || power_on_reset;               // [R12] [R02]

   // ****************************************
   // Reset sequencing
   // ****************************************
   always_comb begin
      next_state = state;
      next_hold_cnt = hold_cnt;
      case (state)
         RST_IDLE: begin
            if (any_rst) begin
               next_state = RST_HOLD;
            end
         end
         RST_HOLD: begin
            next_hold_cnt = 5'(HOLD_CYCLES);
            if (!any_rst && !(pin_fn && pin_low)) begin
               next_state = RST_RELEASE;                        // [R02]
            end
         end
         RST_RELEASE: begin
            if (any_rst) begin
               next_state = RST_HOLD;
            end else if (hold_cnt == 5'h00) begin
               next_state = RST_IDLE;
            end else begin
               next_hold_cnt = hold_cnt - 5'h01;
            end
         end
         default: next_state = RST_IDLE;
      endcase
   end

   // ****************************************
   // Watchdog counter
   // ****************************************
   // Any reset, clear or disable restarts the count from zero, so a
   // watchdog reset can never retrigger while the sequencer is busy
   always_comb begin
      next_wdt_cnt = wdt_cnt + 16'h0001;
      if (state != RST_IDLE || watchdog_clear_instruction
          || !ctrl[`RSC_CTRL_WDTEN]) begin
         next_wdt_cnt = 16'h0000;
      end
   end

   // ****************************************
   // Cause flags, registers, interrupts
   // ****************************************
   always_comb begin
      next_cause = cause;
      next_ctrl = ctrl;
      next_irq_st = irq_st;
      next_irq_msk = irq_msk;
      next_wdt_timeout = wdt_timeout;
      next_wdt_window = wdt_window;
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            `RSC_ADDR_CAUSE:   next_rdata = cause;
            `RSC_ADDR_CTRL:    next_rdata = ctrl;
            `RSC_ADDR_IRQ_ST:  next_rdata = {3'h0, irq_st};
            `RSC_ADDR_IRQ_MSK: next_rdata = {3'h0, irq_msk};
            `RSC_ADDR_WDT:     next_rdata = wdt_timeout[7:0];
            `RSC_ADDR_WDT_HI:  next_rdata = wdt_timeout[15:8];
            `RSC_ADDR_WIN:     next_rdata = wdt_window[7:0];
            default:           next_rdata = 8'h00;
         endcase
         if (addr == `RSC_ADDR_IRQ_ST) begin
            next_irq_st = 5'h00;
         end
      end
      if (wr) begin
         case (addr)
            `RSC_ADDR_CAUSE:   next_cause = wdata;              // [R12]
            `RSC_ADDR_CTRL:    next_ctrl = wdata;
            `RSC_ADDR_IRQ_MSK: next_irq_msk = wdata[4:0];
            `RSC_ADDR_WDT:     next_wdt_timeout =
                                  merge_lo(wdt_timeout, wdata);
            `RSC_ADDR_WDT_HI:  next_wdt_timeout =
                                  merge_hi(wdt_timeout, wdata);
            // Clears before this count are window violations
            `RSC_ADDR_WIN:     next_wdt_window =
                                  merge_lo(wdt_window, wdata);  // [R06]
            default:           next_wdt_window = wdt_window;
         endcase
      end
      // Events after the clear so a same-cycle event survives the read
      if (sleep_instruction) begin
         next_cause[`RSC_CAUSE_PD] = 1'b0;
      end
      if (watchdog_clear_instruction && !wdt_early) begin
         next_cause[`RSC_CAUSE_TO] = 1'b1;
         next_cause[`RSC_CAUSE_PD] = 1'b1;
      end
      if (wdt_expire || wdt_early) begin
         next_cause[`RSC_CAUSE_TO] = 1'b0;                      // [R07]
         next_cause[`RSC_CAUSE_PD] = 1'b1;                      // [R07]
         next_cause[`RSC_CAUSE_WATCHDOG_RESET_FLAG_N] = 1'b0;                    // [R07]
         next_cause[`RSC_CAUSE_WV] = !wdt_early;                // [R08]
         next_irq_st[`RSC_IRQ_WDT] = 1'b1;
      end
      if (reset_instruction) begin
         next_cause[`RSC_CAUSE_RI] = 1'b0;                      // [R09]
         next_irq_st[`RSC_IRQ_RI] = 1'b1;
      end
      if (stack_rst) begin
         if (stack_overflow) begin
            next_cause[`RSC_CAUSE_OVF] = 1'b1;                  // [R11]
         end
         if (stack_underflow) begin
            next_cause[`RSC_CAUSE_UNF] = 1'b1;                  // [R11]
         end
         next_irq_st[`RSC_IRQ_STACK] = 1'b1;
      end
      if (pin_fn && pin_low && state == RST_IDLE) begin
         next_irq_st[`RSC_IRQ_PIN] = 1'b1;
      end
      if (brownout_reset) begin
         next_irq_st[`RSC_IRQ_BOR] = 1'b1;
      end
   end

   // ****************************************
   // Output terms
   // ****************************************
   always_comb begin
      // Pull-up forced on for the reset function, software-owned otherwise
      next_pin_pullup_en = pin_fn | ctrl[`RSC_CTRL_PULLUP];     // [R05]
      next_pin_is_reset = pin_fn;                               // [R01] [R05]
      next_device_reset = any_rst || state != RST_IDLE;         // [R12]
      next_irq = |(next_irq_st & next_irq_msk);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= RST_IDLE;
         hold_cnt <= 5'h00;
         ctrl <= `RSC_CTRL_RESET;
         irq_st <= 5'h00;
         irq_msk <= 5'h00;
         wdt_cnt <= 16'h0000;
         wdt_timeout <= `RSC_WDT_TIMEOUT;
         wdt_window <= `RSC_WDT_WINDOW;
         rdata <= 8'h00;
         pin_pullup_en <= 1'b1;
         pin_is_reset <= 1'b1;
         device_reset <= 1'b1;
         irq <= 1'b0;
         master_clear_pin_out <= 1'b0;
         master_clear_pin_oe <= 1'b0;
      end else begin
         state <= next_state;
         hold_cnt <= next_hold_cnt;
         ctrl <= next_ctrl;
         irq_st <= next_irq_st;
         irq_msk <= next_irq_msk;
         wdt_cnt <= next_wdt_cnt;
         wdt_timeout <= next_wdt_timeout;
         wdt_window <= next_wdt_window;
         rdata <= next_rdata;
         pin_pullup_en <= next_pin_pullup_en;
         pin_is_reset <= next_pin_is_reset;
         device_reset <= next_device_reset;
         irq <= next_irq;
         // The pin is an input only; no reset source ever drives it
         master_clear_pin_out <= 1'b0;                          // [R04]
         master_clear_pin_oe <= 1'b0;                           // [R04]
      end
   end

   // Cause flags survive every reset except power-on
   always_ff @(posedge clk) begin
      if (power_on_reset) begin
         cause <= `RSC_CAUSE_RESET;                             // [R12]
      end else begin
         cause <= next_cause;
      end
   end
endmodule : reset_source_control
`default_nettype wire

/* File: reset_source_control_monitor.sv */
// Port checker for the reset source controller, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module reset_source_control_chk #(
   parameter int FILTER_CYCLES = 20
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic power_on_reset,
   input wire logic brownout_reset,
   input wire logic ext_reset_pin_enable,
   input wire logic low_voltage_program_enable,
   input wire logic stack_fault_reset_enable,
   input wire logic master_clear_pin_in,
   input wire logic reset_instruction,
   input wire logic stack_overflow,
   input wire logic stack_underflow,
   input wire logic master_clear_pin_out,
   input wire logic master_clear_pin_oe,
   input wire logic pin_pullup_en,
   input wire logic pin_is_reset,
   input wire logic device_reset
);
   int lowcnt;
   int next_lowcnt;
   logic quiet;
   // ****************************************
   // Helper: run of qualified low pin cycles
   // ****************************************
   always_comb begin
      next_lowcnt = lowcnt + 1;
      if (sys_rst || master_clear_pin_in || !pin_is_reset)
         next_lowcnt = 0;
   end
   always_ff @(posedge clk) begin
      lowcnt <= next_lowcnt;
   end
   assign quiet = !(power_on_reset || brownout_reset || reset_instruction)
                  && master_clear_pin_in && !device_reset;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_held;
      device_reset [*2];
   endsequence
   sequence s_fault;
      stack_fault_reset_enable && (stack_overflow || stack_underflow);
   endsequence
   AST_PIN_IDLE: assert property (!master_clear_pin_oe && !master_clear_pin_out)
      else $error("reset pin driven by the device");
   AST_PIN_FUNC: assert property (!$past(sys_rst) |-> pin_is_reset ==
      $past(low_voltage_program_enable | ext_reset_pin_enable))
      else $error("pin function enable wrong");
   AST_PULLUP_ON: assert property (pin_is_reset |-> pin_pullup_en)
      else $error("pull-up off while pin function on");
   AST_PIN_HOLD: assert property (lowcnt >= FILTER_CYCLES + 4 |-> device_reset)
      else $error("low pin not holding reset");
   AST_RI: assert property (reset_instruction |=> s_held)
      else $error("reset instruction ignored");
   AST_STACK_ON: assert property (s_fault |=> s_held)
      else $error("enabled stack fault ignored");
   AST_STACK_OFF: assert property (!stack_fault_reset_enable && quiet &&
      (stack_overflow || stack_underflow) |=> !device_reset)
      else $error("disabled stack fault reset the device");
   AST_BOR: assert property (brownout_reset |=> device_reset)
      else $error("brown-out not merged into reset");
endmodule : reset_source_control_chk
bind reset_source_control reset_source_control_chk #(
   .FILTER_CYCLES(FILTER_CYCLES)
) u_chk (
   .clk, .sys_rst, .power_on_reset, .brownout_reset, .ext_reset_pin_enable,
   .low_voltage_program_enable, .stack_fault_reset_enable,
   .master_clear_pin_in, .reset_instruction, .stack_overflow,
   .stack_underflow, .master_clear_pin_out, .master_clear_pin_oe,
   .pin_pullup_en, .pin_is_reset, .device_reset
);
`default_nettype wire

/* File: reset_pin_model.sv */
// Far-side model: board driver on the reset pin and the pin's pull-up
`timescale 1ns/1ps
`default_nettype none
module reset_pin_model (
   input  wire logic clk,
   input  wire logic pull_low,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   input  wire logic pullup_en,
   output logic      pin
);
   logic toggle = 1'h0;
   // Floating pin keeps moving so nothing leans on a settled value
   always_ff @(posedge clk) begin
      toggle <= ~toggle;
   end
   always_comb begin
      if (pull_low)
         pin = 1'h0;
      else if (pin_oe)
         pin = pin_out;
      else if (pullup_en)
         pin = 1'h1;
      else
         pin = toggle;
   end
endmodule : reset_pin_model
`default_nettype wire

/* File: reset_source_control_test.sv */
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_control_map.svh"
module reset_source_control_test;
   localparam int FILT = 4;
   localparam int HOLD = 4;
   logic clk = 1'h0, sys_rst = 1'h1, power_on_reset = 1'h1;
   logic brownout_reset = 1'h0, ext_reset_pin_enable = 1'h0;
   logic low_voltage_program_enable = 1'h0, stack_fault_reset_enable = 1'h0;
   logic watchdog_clear_instruction = 1'h0, reset_instruction = 1'h0;
   logic sleep_instruction = 1'h0, stack_overflow = 1'h0;
   logic stack_underflow = 1'h0, pull_low = 1'h0, wr = 1'h0, rd = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] exp_q[$];
   reset_source_pkg::reg_byte_t rdata;
   logic master_clear_pin_in, master_clear_pin_out, master_clear_pin_oe;
   logic pin_pullup_en, pin_is_reset, device_reset, irq, rd_d = 1'h0;
   int n_fail = 0, compares = 0, cycles = 0, len;
   always #5 clk = ~clk;
   reset_pin_model u_pin (.clk, .pull_low, .pin_out(master_clear_pin_out),
      .pin_oe(master_clear_pin_oe), .pullup_en(pin_pullup_en),
      .pin(master_clear_pin_in));
   reset_source_control #(.FILTER_CYCLES(FILT), .HOLD_CYCLES(HOLD)) DUT (
      .clk, .sys_rst, .power_on_reset, .brownout_reset, .ext_reset_pin_enable,
      .low_voltage_program_enable, .stack_fault_reset_enable,
      .master_clear_pin_in, .watchdog_clear_instruction, .reset_instruction,
      .sleep_instruction, .stack_overflow, .stack_underflow, .addr, .wdata,
      .wr, .rd, .rdata, .master_clear_pin_out, .master_clear_pin_oe,
      .pin_pullup_en, .pin_is_reset, .device_reset, .irq);
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic test_done(bit hung);
      if (hung)
         n_fail++;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task automatic bus(logic [3:0] a, logic [7:0] d, bit is_rd);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= !is_rd;
      rd <= is_rd;
      @(posedge clk);
      wr <= 1'h0;
      rd <= 1'h0;
   endtask : bus
   task automatic rd_reg(logic [3:0] a, logic [7:0] exp);
      exp_q.push_back(exp);
      bus(a, 8'h00, 1'h1);
   endtask : rd_reg
   task automatic pull(int n);
      @(posedge clk);
      pull_low <= 1'h1;
      repeat (n) @(posedge clk);
      pull_low <= 1'h0;
   endtask : pull
   // Ends on an edge: outputs read before it, inputs driven by NBA on it
   task automatic settle(int n);
      repeat (n) @(posedge clk);
      @(posedge clk);
   endtask : settle
   // Bounded: a stuck reset must not hang the run
   task automatic wait_free();
      for (int i = 0; i < 60 && device_reset !== 1'h0; i++)
         @(posedge clk);
      check("device_reset", device_reset, 8'h00);
   endtask : wait_free
   // ****************************************
   // Result watcher: oldest note against read data
   // ****************************************
   always @(posedge clk) begin
      rd_d <= rd;
      cycles <= cycles + 1;
      if (rd_d)
         check("rdata", rdata, exp_q.pop_front());
      if (cycles > 3000)
         test_done(1'h1);
   end
   initial begin
      len = $urandom(32'h3654);
      settle(1);
      sys_rst <= 1'h0;
      settle(1);
      power_on_reset <= 1'h0;
      wait_free();
      rd_reg(`RSC_ADDR_CAUSE, `RSC_CAUSE_RESET);
      bus(`RSC_ADDR_CTRL, 8'h00, 1'h0);
      rd_reg(`RSC_ADDR_CTRL, 8'h00);
      rd_reg(4'hF, 8'h00);
      for (int i = 0; i < 4; i++) begin
         {low_voltage_program_enable, ext_reset_pin_enable} <= i[1:0];
         settle(3);
         check("pin_is_reset", pin_is_reset, 8'(i != 0));
         check("pin_pullup_en", pin_pullup_en, 8'(i != 0));
         check("pin_oe", master_clear_pin_oe, 8'h00);
      end
      $display("test config done");
      low_voltage_program_enable <= 1'h0;
      repeat (3) pull(1 + $urandom % FILT);
      settle(3);
      check("device_reset", device_reset, 8'h00);
      pull_low <= 1'h1;
      settle(FILT + 12);
      check("device_reset", device_reset, 8'h01);
      pull_low <= 1'h0;
      wait_free();
      bus(`RSC_ADDR_IRQ_MSK, 8'h1F, 1'h0);
      settle(2);
      check("irq", irq, 8'h01);
      rd_reg(`RSC_ADDR_IRQ_ST, 8'h01);
      settle(2);
      check("irq", irq, 8'h00);
      $display("test pin done");
      ext_reset_pin_enable <= 1'h0;
      bus(`RSC_ADDR_CTRL, 8'h01, 1'h0);
      settle(2);
      check("pin_pullup_en", pin_pullup_en, 8'h01);
      pull(FILT + 10);
      settle(1);
      check("device_reset", device_reset, 8'h00);
      bus(`RSC_ADDR_CTRL, 8'h00, 1'h0);
      reset_instruction <= 1'h1;
      @(posedge clk);
      reset_instruction <= 1'h0;
      wait_free();
      rd_reg(`RSC_ADDR_CAUSE, 8'h0F);
      rd_reg(`RSC_ADDR_IRQ_ST, 8'h04);
      bus(`RSC_ADDR_CAUSE, 8'h1F, 1'h0);
      rd_reg(`RSC_ADDR_CAUSE, 8'h1F);
      stack_overflow <= 1'h1;
      @(posedge clk);
      stack_overflow <= 1'h0;
      settle(2);
      check("device_reset", device_reset, 8'h00);
      stack_fault_reset_enable <= 1'h1;
      stack_overflow <= 1'h1;
      @(posedge clk);
      stack_overflow <= 1'h0;
      wait_free();
      rd_reg(`RSC_ADDR_CAUSE, 8'h3F);
      stack_underflow <= 1'h1;
      @(posedge clk);
      stack_underflow <= 1'h0;
      wait_free();
      rd_reg(`RSC_ADDR_CAUSE, 8'h7F);
      bus(`RSC_ADDR_CAUSE, 8'h1F, 1'h0);
      brownout_reset <= 1'h1;
      @(posedge clk);
      brownout_reset <= 1'h0;
      wait_free();
      sleep_instruction <= 1'h1;
      @(posedge clk);
      sleep_instruction <= 1'h0;
      rd_reg(`RSC_ADDR_CAUSE, 8'h1D);
      $display("test sources done");
      bus(`RSC_ADDR_WDT, 8'h10, 1'h0);
      bus(`RSC_ADDR_WDT_HI, 8'h00, 1'h0);
      bus(`RSC_ADDR_CTRL, 8'h02, 1'h0);
      repeat (8) begin
         repeat (6) @(posedge clk);
         watchdog_clear_instruction <= 1'h1;
         @(posedge clk);
         watchdog_clear_instruction <= 1'h0;
      end
      settle(1);
      check("device_reset", device_reset, 8'h00);
      for (int i = 0; i < 100 && device_reset !== 1'h1; i++)
         @(posedge clk);
      check("device_reset", device_reset, 8'h01);
      bus(`RSC_ADDR_CTRL, 8'h00, 1'h0);
      wait_free();
      rd_reg(`RSC_ADDR_CAUSE, 8'h1A);
      bus(`RSC_ADDR_CAUSE, 8'h1F, 1'h0);
      bus(`RSC_ADDR_WIN, 8'h08, 1'h0);
      rd_reg(`RSC_ADDR_WIN, 8'h08);
      bus(`RSC_ADDR_CTRL, 8'h02, 1'h0);
      watchdog_clear_instruction <= 1'h1;
      @(posedge clk);
      watchdog_clear_instruction <= 1'h0;
      settle(1);
      check("device_reset", device_reset, 8'h01);
      bus(`RSC_ADDR_CTRL, 8'h00, 1'h0);
      wait_free();
      rd_reg(`RSC_ADDR_CAUSE, 8'h12);
      settle(2);
      $display("test watchdog done");
      test_done(1'h0);
   end
endmodule : reset_source_control_test
`default_nettype wire
